// file: inc/svt_map.vh
`ifndef SVT_MAP_VH
`define SVT_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SVT_ADDR_BUS_ERROR_STATUS 8'h11
`define SVT_ADDR_TEMPERATURE_ZONE 8'h12
`define SVT_ADDR_BUS_ERROR_LAST_READ 8'h1C
`define SVT_ADDR_MAX_CURRENT_REPORT 8'h21
`define SVT_ADDR_TEMPERATURE_LIMIT 8'h22
`define SVT_ADDR_FAST_SLEW_REPORT 8'h24
`define SVT_ADDR_SLOW_SLEW_REPORT 8'h25

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SVT_ERR_PARITY_BIT 0
`define SVT_ERR_FRAME_BIT 1
`define SVT_ZONE_ALERT_BIT 6
`define SVT_ZONE_HOT_BIT 7

// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define SVT_BYTE_ZERO 8'h00
`define SVT_ERR_RESET 8'h00
`define SVT_TEMPERATURE_LIMIT_VALUE 8'h64
`define SVT_SLEW_FAST_HIGH 8'h14
`define SVT_SLEW_FAST_LOW 8'h0A
`define SVT_SLOW_SHIFT 2

// ----------------------------------------------------------------
// slew strap levels (0 V, 1.5 V, 3 V, supply)
// ----------------------------------------------------------------
`define SVT_SLEW_LVL_0V 2'h0
`define SVT_SLEW_LVL_1V5 2'h1
`define SVT_SLEW_LVL_3V 2'h2
`define SVT_SLEW_LVL_VCC 2'h3

// ----------------------------------------------------------------
// current limit strap levels
// ----------------------------------------------------------------
`define SVT_CURRENT_LIMIT_STRAP_LVL_LOW_OFF 5'h00
`define SVT_CURRENT_LIMIT_STRAP_LVL_FIRST 5'h01
`define SVT_CURRENT_LIMIT_STRAP_LVL_LAST 5'h10
`define SVT_ICC_STEP0 6'h23
`define SVT_ICC_STEP1 6'h21
`define SVT_ICC_STEP2_A 6'h1B
`define SVT_ICC_STEP3_A 6'h16
`define SVT_ICC_STEP2_B 6'h16
`define SVT_ICC_STEP3_B 6'h11

// ----------------------------------------------------------------
// strap capture timing
// ----------------------------------------------------------------
`define SVT_STRAP_WAIT 3'h4

`endif

// file: logic/svt_status_regs.v
// How it works
// (R01) parity errors set bit 0 and frame errors set bit 1 of bus_error_status, bits 7..2 read zero.
// (R02) a read of bus_error_status copies it into bus_error_last_read and then clears it.
// (R03) the bus master may fetch bus_error_last_read to recover error status lost to a corrupted reply.
// (R04) temperature_zone is a thermometer code of both thermistor comparators at 75..100 percent.
// (R05) the 97 percent bit at either input sets the thermal alert status bit and pulls alert_n low.
// (R06) the 100 percent bit for either regulator pulls hot_out_n low.
// (R07) hot_out_n comes straight from the comparators, free of the register file and bus.
// (R08) temperature_limit reads a fixed 100 degrees, 64h, shared by both regulators.
// (R09) capability registers come from straps captured after reset, never from bus writes.
// (R10) max_current_report is the per-phase strap limit times active phases, one amp per step.
// (R11) an out-of-range current limit strap latches the affected regulator off.
// (R12) fast_slew_report gives the minimum fast slew in mV/us, defaulting to 0Ah.
// (R13) slew strap at 1.5 V or 3 V selects the higher fast rate, 0 V or supply the lower.
// (R14) slow_slew_report is one quarter of the fast rate in the same format.
// (R15) the overcurrent alert status bit latches when set and a primary status read refreshes it.
// (R16) temperature_zone follows the comparators continuously, each bit clearing when no longer exceeded.
`timescale 1ns/1ps
`include "svt_map.vh"
module svt_status_regs #(
  parameter ZONE_BITS = 8,
  parameter LVL_BITS = 5
) (
  input wire clk,
  input wire arst_n,
  // register access from the serial frame engine (same clock)
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire reg_vr_sel,
  output reg [7:0] reg_rdata,
  output reg reg_rd_valid,
  output reg reg_rd_nak,
  // error events from the frame engine (same clock)
  input wire parity_err_evt,
  input wire frame_err_evt,
  // primary status read strobe from the frame engine
  input wire primary_status_rd,
  // analog comparator and strap inputs (asynchronous)
  input wire [ZONE_BITS-1:0] thermistor_in_a,
  input wire [ZONE_BITS-1:0] thermistor_in_b,
  input wire [LVL_BITS-1:0] current_limit_strap_a,
  input wire [LVL_BITS-1:0] current_limit_strap_b,
  input wire [1:0] slew_strap,
  input wire [1:0] active_phases_a,
  input wire [1:0] active_phases_b,
  input wire overcurrent_in,
  // outputs
  output reg alert_n,
  output reg hot_out_n,
  output reg primary_therm_alert,
  output reg primary_occ_alert,
  output reg reg_a_off,
  output reg reg_b_off
);

  // --------------------------------------------------------------
  // synchronisers for all asynchronous inputs
  // --------------------------------------------------------------
  localparam SYNC_W = 2 * ZONE_BITS + 2 * LVL_BITS + 2 + 2 + 2 + 1;

  wire [SYNC_W-1:0] async_bus;
  wire [SYNC_W-1:0] sync_bus;
  wire [ZONE_BITS-1:0] cmp_a;
  wire [ZONE_BITS-1:0] cmp_b;
  wire [LVL_BITS-1:0] lvl_a;
  wire [LVL_BITS-1:0] lvl_b;
  wire [1:0] slew_lvl;
  wire [1:0] ph_a;
  wire [1:0] ph_b;
  wire occ_now;

  assign async_bus = {thermistor_in_a, thermistor_in_b, current_limit_strap_a, current_limit_strap_b,
                      slew_strap, active_phases_a, active_phases_b, overcurrent_in};

  svt_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  assign {cmp_a, cmp_b, lvl_a, lvl_b, slew_lvl, ph_a, ph_b, occ_now} = sync_bus;

  // --------------------------------------------------------------
  // per-phase current lookup
  // --------------------------------------------------------------
  // valid levels repeat a four-step pattern of per-phase report values
  function [5:0] icc_per_phase;
    input [LVL_BITS-1:0] lvl;
    input is_b;
    reg [LVL_BITS-1:0] idx;
    begin
      idx = lvl - `SVT_CURRENT_LIMIT_STRAP_LVL_FIRST;
      case (idx[1:0])
        2'h0: icc_per_phase = `SVT_ICC_STEP0;
        2'h1: icc_per_phase = `SVT_ICC_STEP1;
        2'h2: icc_per_phase = is_b ? `SVT_ICC_STEP2_B : `SVT_ICC_STEP2_A;
        2'h3: icc_per_phase = is_b ? `SVT_ICC_STEP3_B : `SVT_ICC_STEP3_A;
        default: icc_per_phase = 6'h00;
      endcase
    end
  endfunction

  // level inside the defined window
  function lvl_ok;
    input [LVL_BITS-1:0] lvl;
    begin
      lvl_ok = (lvl >= `SVT_CURRENT_LIMIT_STRAP_LVL_FIRST) && (lvl <= `SVT_CURRENT_LIMIT_STRAP_LVL_LAST);
    end
  endfunction

  // --------------------------------------------------------------
  // strap capture after reset release
  // --------------------------------------------------------------
  reg [2:0] strap_wait;
  reg straps_taken;
  reg [7:0] icc_a;
  reg [7:0] icc_b;
  reg [7:0] fast_slew;
  reg [7:0] slow_slew;
  wire [7:0] next_icc_a;
  wire [7:0] next_icc_b;
  wire [7:0] next_fast_slew;
  wire [9:0] prod_a;
  wire [9:0] prod_b;

  // limit per phase times phase count
  assign prod_a = icc_per_phase(lvl_a, 1'b0) * {2'h0, ph_a}; // R10
  assign prod_b = icc_per_phase(lvl_b, 1'b1) * {2'h0, ph_b}; // R10
  assign next_icc_a = lvl_ok(lvl_a) ? prod_a[7:0] : `SVT_BYTE_ZERO;
  assign next_icc_b = lvl_ok(lvl_b) ? prod_b[7:0] : `SVT_BYTE_ZERO;

  // mid strap levels give the higher fast rate
  assign next_fast_slew = ((slew_lvl == `SVT_SLEW_LVL_1V5) || (slew_lvl == `SVT_SLEW_LVL_3V)) ?
                          `SVT_SLEW_FAST_HIGH : `SVT_SLEW_FAST_LOW; // R13

  // wait for the synchronisers to fill, then sample straps once
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait <= 3'h0;
      straps_taken <= 1'b0;
      icc_a <= `SVT_BYTE_ZERO;
      icc_b <= `SVT_BYTE_ZERO;
      fast_slew <= `SVT_SLEW_FAST_LOW; // R12
      slow_slew <= `SVT_SLEW_FAST_LOW >> `SVT_SLOW_SHIFT;
    end else if (!straps_taken) begin
      if (strap_wait == `SVT_STRAP_WAIT) begin
        straps_taken <= 1'b1; // R09
        icc_a <= next_icc_a; // R10
        icc_b <= next_icc_b; // R10
        fast_slew <= next_fast_slew; // R12
        slow_slew <= next_fast_slew >> `SVT_SLOW_SHIFT; // R14
      end else begin
        strap_wait <= strap_wait + 3'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // regulator latch-off on bad current limit strap
  // --------------------------------------------------------------
  // once off, only a reset brings the regulator back
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_a_off <= 1'b0;
      reg_b_off <= 1'b0;
    end else if (!straps_taken && (strap_wait == `SVT_STRAP_WAIT)) begin
      if (!lvl_ok(lvl_a)) begin
        reg_a_off <= 1'b1; // R11
      end
      if (!lvl_ok(lvl_b)) begin
        reg_b_off <= 1'b1; // R11
      end
    end
  end

  // --------------------------------------------------------------
  // temperature zone and thermal outputs
  // --------------------------------------------------------------
  reg [ZONE_BITS-1:0] zone;
  wire [ZONE_BITS-1:0] next_zone;

  // either thermistor trips a zone bit
  assign next_zone = cmp_a | cmp_b; // R04

  // follow comparators every cycle, bits drop as soon as they clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zone <= {ZONE_BITS{1'b0}};
    end else begin
      zone <= next_zone; // R16
    end
  end

  // alert and hot pins straight from comparators, not the register path
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_n <= 1'b1;
      hot_out_n <= 1'b1;
      primary_therm_alert <= 1'b0;
    end else begin
      primary_therm_alert <= next_zone[`SVT_ZONE_ALERT_BIT]; // R05
      alert_n <= ~next_zone[`SVT_ZONE_ALERT_BIT]; // R05
      hot_out_n <= ~(cmp_a[`SVT_ZONE_HOT_BIT] | cmp_b[`SVT_ZONE_HOT_BIT]); // R06 R07
    end
  end

  // --------------------------------------------------------------
  // overcurrent alert latch
  // --------------------------------------------------------------
  // a rising alert sticks; a primary status read reloads the live value
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_occ_alert <= 1'b0;
    end else if (primary_status_rd) begin
      primary_occ_alert <= occ_now; // R15
    end else if (occ_now) begin
      primary_occ_alert <= 1'b1; // R15
    end
  end

  // --------------------------------------------------------------
  // bus error status and last-read copy
  // --------------------------------------------------------------
  reg [1:0] err_stat;
  reg [1:0] err_last;
  wire [1:0] err_evt;
  wire err_rd;

  assign err_evt = {frame_err_evt, parity_err_evt}; // R01
  assign err_rd = reg_rd && (reg_addr == `SVT_ADDR_BUS_ERROR_STATUS);

  // new events survive a clearing read of the same cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_stat <= 2'h0;
      err_last <= 2'h0;
    end else if (err_rd) begin
      err_last <= err_stat; // R02
      err_stat <= err_evt; // R02
    end else begin
      err_stat <= err_stat | err_evt; // R01
    end
  end

  // --------------------------------------------------------------
  // read data mux
  // --------------------------------------------------------------
  reg [7:0] next_rdata;
  reg next_nak;

  // select register contents by offset, current limit report picked per regulator
  always @* begin
    next_rdata = `SVT_BYTE_ZERO;
    next_nak = 1'b0;
    case (reg_addr)
      `SVT_ADDR_BUS_ERROR_STATUS: begin
        next_rdata = {6'h00, err_stat}; // R01
      end
      `SVT_ADDR_TEMPERATURE_ZONE: begin
        next_rdata = zone; // R04
      end
      `SVT_ADDR_BUS_ERROR_LAST_READ: begin
        next_rdata = {6'h00, err_last}; // R02
      end
      `SVT_ADDR_MAX_CURRENT_REPORT: begin
        next_rdata = reg_vr_sel ? icc_b : icc_a; // R10
      end
      `SVT_ADDR_TEMPERATURE_LIMIT: begin
        next_rdata = `SVT_TEMPERATURE_LIMIT_VALUE; // R08
      end
      `SVT_ADDR_FAST_SLEW_REPORT: begin
        next_rdata = fast_slew; // R12
      end
      `SVT_ADDR_SLOW_SLEW_REPORT: begin
        next_rdata = slow_slew; // R14
      end
      default: begin
        next_nak = 1'b1;
      end
    endcase
  end

  // answer one cycle after the read strobe
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `SVT_BYTE_ZERO;
      reg_rd_valid <= 1'b0;
      reg_rd_nak <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      reg_rd_nak <= reg_rd & next_nak;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule // svt_status_regs

// file: logic/svt_sync.v
`timescale 1ns/1ps
module svt_sync #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire arst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------
  // two-stage synchroniser, one pair per bit
  // --------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta;
      reg stable;
      // first stage feeds only the second
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= async_in[gi];
          stable <= meta;
        end
      end
      assign sync_out[gi] = stable;
    end
  endgenerate

endmodule // svt_sync

// file: verification/svt_status_regs_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// read answer, thermal and overcurrent output checks
// ----------------------------------------
module svt_status_regs_props #(
  parameter ZONE_BITS = 8,
  parameter LVL_BITS = 5
) (
  input wire clk,
  input wire arst_n,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  input wire reg_rd_nak,
  input wire primary_status_rd,
  input wire [ZONE_BITS-1:0] thermistor_in_a,
  input wire [ZONE_BITS-1:0] thermistor_in_b,
  input wire overcurrent_in,
  input wire alert_n,
  input wire hot_out_n,
  input wire primary_therm_alert,
  input wire primary_occ_alert
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // comparator levels held across the sync stages
  sequence s_hot_on; (thermistor_in_a[7] | thermistor_in_b[7]) [*3]; endsequence
  sequence s_hot_off; !(thermistor_in_a[7] | thermistor_in_b[7]) [*3]; endsequence
  sequence s_alert_on; (thermistor_in_a[6] | thermistor_in_b[6]) [*3]; endsequence
  sequence s_alert_off; !(thermistor_in_a[6] | thermistor_in_b[6]) [*3]; endsequence
  sequence s_read_of(a); reg_rd && reg_addr == a; endsequence
  a_read_answer_next: assert property (reg_rd |=> reg_rd_valid) else $error("read not answered");
  a_nak_reads_zero: assert property (reg_rd_nak |-> reg_rd_valid && reg_rdata == 8'h00) else $error("nak data");
  a_err_reserved_zero: assert property (s_read_of(8'h11) |=> reg_rdata[7:2] == 6'h00) else $error("err rsv");
  a_limit_fixed_value: assert property (s_read_of(8'h22) |=> !reg_rd_nak && reg_rdata == 8'h64) else $error("limit");
  a_zone_tracks_outputs: assert property (s_read_of(8'h12) |=> reg_rdata[7] == !$past(hot_out_n)) else $error("zone");
  a_hot_goes_low: assert property (s_hot_on |=> !hot_out_n) else $error("hot not low");
  a_hot_goes_high: assert property (s_hot_off |=> hot_out_n) else $error("hot not high");
  a_alert_goes_low: assert property (s_alert_on |=> !alert_n && primary_therm_alert) else $error("alert on");
  a_alert_goes_high: assert property (s_alert_off |=> alert_n && !primary_therm_alert) else $error("alert off");
  a_occ_sets_up: assert property (overcurrent_in [*3] |=> primary_occ_alert) else $error("occ set");
  a_occ_stays_latched: assert property (primary_occ_alert && !primary_status_rd |=> primary_occ_alert)
    else $error("occ dropped");
endmodule // svt_status_regs_props

// file: verification/svt_svid_master.sv
`timescale 1ns/1ps
// ----------------------------------------
// bus master model
// ----------------------------------------
module svt_svid_master (
  input wire clk,
  input wire [7:0] reg_rdata,
  input wire reg_rd_valid,
  input wire reg_rd_nak,
  output reg reg_rd,
  output reg [7:0] reg_addr,
  output reg reg_vr_sel,
  output reg parity_err_evt,
  output reg frame_err_evt,
  output reg primary_status_rd
);
  // idle bus at time zero
  initial begin
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_vr_sel = 1'b0;
    parity_err_evt = 1'b0;
    frame_err_evt = 1'b0;
    primary_status_rd = 1'b0;
  end
  // one read, answer taken while valid stands
  task get_reg(input [7:0] addr, input sel, output [7:0] data, output nak, output ok);
    integer i;
    begin
      ok = 1'b0;
      data = 8'h00;
      nak = 1'b0;
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = addr;
      reg_vr_sel = sel;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~addr; // released address carries junk
      reg_vr_sel = ~sel;
      for (i = 0; i < 4 && !ok; i = i + 1) begin
        if (reg_rd_valid === 1'b1) begin
          ok = 1'b1;
          data = reg_rdata;
          nak = reg_rd_nak;
        end else begin
          @(negedge clk);
        end
      end
    end
  endtask
  // one-cycle event pulses
  task pulse(input p, input f, input s);
    begin
      @(negedge clk);
      parity_err_evt = p;
      frame_err_evt = f;
      primary_status_rd = s;
      @(negedge clk);
      parity_err_evt = 1'b0;
      frame_err_evt = 1'b0;
      primary_status_rd = 1'b0;
    end
  endtask
endmodule // svt_svid_master

// file: verification/test_svid_status_telemetry_regs.sv
`timescale 1ns/1ps
module test_svid_status_telemetry_regs;
  reg clk;
  reg arst_n;
  reg [7:0] thermistor_in_a;
  reg [7:0] thermistor_in_b;
  reg [4:0] current_limit_strap_a;
  reg [4:0] current_limit_strap_b;
  reg [1:0] slew_strap;
  reg [1:0] active_phases_a;
  reg [1:0] active_phases_b;
  reg overcurrent_in;
  wire reg_rd, reg_vr_sel, reg_rd_valid, reg_rd_nak, parity_err_evt, frame_err_evt, primary_status_rd;
  wire [7:0] reg_addr;
  wire [7:0] reg_rdata;
  wire alert_n, hot_out_n, primary_therm_alert, primary_occ_alert, reg_a_off, reg_b_off;
  reg last_nak;
  integer err_total = 0;
  integer samples_checked = 0;
  integer k;
  svt_svid_master m (.clk(clk), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_rd_nak(reg_rd_nak),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_vr_sel(reg_vr_sel), .parity_err_evt(parity_err_evt),
    .frame_err_evt(frame_err_evt), .primary_status_rd(primary_status_rd));
  svt_status_regs #(.ZONE_BITS(8), .LVL_BITS(5)) dut (.clk(clk), .arst_n(arst_n), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_vr_sel(reg_vr_sel), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .reg_rd_nak(reg_rd_nak), .parity_err_evt(parity_err_evt), .frame_err_evt(frame_err_evt),
    .primary_status_rd(primary_status_rd), .thermistor_in_a(thermistor_in_a), .thermistor_in_b(thermistor_in_b),
    .current_limit_strap_a(current_limit_strap_a), .current_limit_strap_b(current_limit_strap_b),
    .slew_strap(slew_strap), .active_phases_a(active_phases_a), .active_phases_b(active_phases_b),
    .overcurrent_in(overcurrent_in), .alert_n(alert_n), .hot_out_n(hot_out_n),
    .primary_therm_alert(primary_therm_alert), .primary_occ_alert(primary_occ_alert),
    .reg_a_off(reg_a_off), .reg_b_off(reg_b_off));
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // verdict and end of run
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // compare one value
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // read through the master and compare
  task rd(input [7:0] addr, input sel, input [7:0] exp);
    reg [7:0] d;
    reg ok;
    begin
      m.get_reg(addr, sel, d, last_nak, ok);
      chk("answer", {7'h00, ok}, 8'h01);
      if (ok !== 1'b1) finish_test;
      else chk($sformatf("reg %h", addr), d, exp);
    end
  endtask
  // reset held six cycles, then strap capture settles
  task do_reset;
    begin
      @(negedge clk);
      arst_n = 1'b0;
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
  // per-phase current report of a strap level
  function [7:0] per_phase(input [4:0] lvl, input is_b);
    begin
      if (lvl == 5'h00 || lvl > 5'h10) per_phase = 8'h00;
      else case ((lvl - 5'h01) % 4)
        0: per_phase = 8'h23;
        1: per_phase = 8'h21;
        2: per_phase = is_b ? 8'h16 : 8'h1B;
        default: per_phase = is_b ? 8'h11 : 8'h16;
      endcase
    end
  endfunction
  // fixed value, unmapped offset and error flags
  task t_errors;
    begin
      rd(8'h22, 1'b0, 8'h64);
      rd(8'h13, 1'b0, 8'h00);
      chk("nak", {7'h00, last_nak}, 8'h01);
      m.pulse(1'b1, 1'b0, 1'b0);
      rd(8'h11, 1'b0, 8'h01);
      rd(8'h1C, 1'b0, 8'h01);
      rd(8'h11, 1'b0, 8'h00);
      rd(8'h1C, 1'b0, 8'h00);
      m.pulse(1'b1, 1'b1, 1'b0);
      rd(8'h11, 1'b0, 8'h03);
      rd(8'h1C, 1'b0, 8'h03);
    end
  endtask
  // thermometer zones on both inputs
  task t_thermal;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        if (k % 2) thermistor_in_b = 8'hFF >> (7 - k);
        else thermistor_in_a = 8'hFF >> (7 - k);
        repeat (4) @(negedge clk);
        chk("hot", {7'h00, hot_out_n}, {7'h00, k != 7});
        chk("alert", {7'h00, alert_n}, {7'h00, k < 6});
        chk("therm", {7'h00, primary_therm_alert}, {7'h00, k >= 6});
        rd(8'h12, 1'b0, 8'hFF >> (7 - k));
      end
      thermistor_in_a = 8'h00;
      thermistor_in_b = 8'h00;
      repeat (4) @(negedge clk);
      chk("hot", {7'h00, hot_out_n}, 8'h01);
      chk("alert", {7'h00, alert_n}, 8'h01);
      chk("therm", {7'h00, primary_therm_alert}, 8'h00);
      rd(8'h12, 1'b0, 8'h00);
    end
  endtask
  // latched overcurrent flag
  task t_occ;
    begin
      overcurrent_in = 1'b1;
      repeat (4) @(negedge clk);
      overcurrent_in = 1'b0;
      repeat (4) @(negedge clk);
      chk("occ", {7'h00, primary_occ_alert}, 8'h01);
      m.pulse(1'b0, 1'b0, 1'b1);
      repeat (2) @(negedge clk);
      chk("occ", {7'h00, primary_occ_alert}, 8'h00);
    end
  endtask
  // strap decode after a fresh reset
  task t_caps(input [1:0] s, input [4:0] la, input [4:0] lb, input [1:0] pa, input [1:0] pb);
    reg [7:0] fast;
    begin
      slew_strap = s;
      current_limit_strap_a = la;
      current_limit_strap_b = lb;
      active_phases_a = pa;
      active_phases_b = pb;
      do_reset;
      fast = (s == 2'h1 || s == 2'h2) ? 8'h14 : 8'h0A;
      rd(8'h24, 1'b0, fast);
      rd(8'h25, 1'b0, fast >> 2);
      rd(8'h21, 1'b0, per_phase(la, 1'b0) * pa);
      rd(8'h21, 1'b1, per_phase(lb, 1'b1) * pb);
      chk("off", {6'h00, reg_b_off, reg_a_off}, {6'h00, lb == 0 || lb > 16, la == 0 || la > 16});
    end
  endtask
  // main sequence
  initial begin
    arst_n = 1'b0;
    thermistor_in_a = 8'h00;
    thermistor_in_b = 8'h00;
    current_limit_strap_a = 5'h01;
    current_limit_strap_b = 5'h01;
    slew_strap = 2'h0;
    active_phases_a = 2'h1;
    active_phases_b = 2'h1;
    overcurrent_in = 1'b0;
    do_reset;
    rd(8'h11, 1'b0, 8'h00);
    t_errors;
    t_thermal;
    t_occ;
    t_caps(2'h0, 5'h03, 5'h04, 2'h3, 2'h2);
    t_caps(2'h1, 5'h10, 5'h09, 2'h1, 2'h3);
    t_caps(2'h2, 5'h00, 5'h0E, 2'h2, 2'h1);
    t_caps(2'h3, 5'h07, 5'h11, 2'h3, 2'h2);
    finish_test;
  end
endmodule // test_svid_status_telemetry_regs
bind svt_status_regs svt_status_regs_props #(.ZONE_BITS(ZONE_BITS), .LVL_BITS(LVL_BITS)) u_props (.clk(clk),
  .arst_n(arst_n), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .reg_rd_nak(reg_rd_nak), .primary_status_rd(primary_status_rd), .thermistor_in_a(thermistor_in_a),
  .thermistor_in_b(thermistor_in_b), .overcurrent_in(overcurrent_in), .alert_n(alert_n), .hot_out_n(hot_out_n),
  .primary_therm_alert(primary_therm_alert), .primary_occ_alert(primary_occ_alert));
